// ==== common/pcst_pkg.sv ====
// Constants and types for the program sequencer block
package pcst_pkg;
	localparam int PC_W = 11;
	localparam int WORD_W = 15;
	localparam int STACK_DEPTH = 4;
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [2:0] LAST_PAGE = 3'h7;
	localparam logic [2:0] DEPTH_FULL = 3'h4;
	// Register byte offsets
	localparam logic [7:0] A_PCL = 8'h00;
	localparam logic [7:0] A_TPL = 8'h04;
	localparam logic [7:0] A_TPH = 8'h08;
	localparam logic [7:0] A_TABLE_HIGH_BYTE_LATCH = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	// Status field positions
	localparam int ST_C = 0;
	localparam int ST_AC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [7:0] DAA_LO = 8'h06;
	localparam logic [8:0] DAA_HI = 9'h060;
	typedef enum logic [3:0] {
		PH_T1 = 4'b0001,
		PH_T2 = 4'b0010,
		PH_T3 = 4'b0100,
		PH_T4 = 4'b1000
	} pcst_phase_e;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_ALU = 4'h1, OP_JUMP = 4'h2, OP_CALL = 4'h3,
		OP_RET = 4'h4, OP_INTERRUPT_RETURN_OP = 4'h5, OP_SKIPZ = 4'h6, OP_SKIPNZ = 4'h7,
		OP_TABRD = 4'h8, OP_TABLE_READ_LAST_PAGE_OP = 4'h9
	} pcst_op_e;
	typedef enum logic [3:0] {
		ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
		ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7,
		ALU_CPL = 4'h8, ALU_RR = 4'h9, ALU_RRC = 4'ha, ALU_RL = 4'hb,
		ALU_RLC = 4'hc, ALU_INC = 4'hd, ALU_DEC = 4'he, ALU_PASS = 4'hf
	} pcst_alu_e;
endpackage : pcst_pkg

// ==== hdl/pcst_sequencer.sv ====
// Program counter, return stack, ALU status and table read sequencer
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Counter steps by one unless branching
// - Eleven-bit counter, only low byte addressable
// - Jump, call, interrupt, reset load target
// - Taken skip discards prefetch, inserts dummy
// - Low byte write jumps within page
// - Low byte readable and writable
// - Low byte write adds dummy cycle
// - Four-level stack, hidden, pointer hidden
// - Call/interrupt push, returns pop
// - Reset leaves stack empty
// - Full stack withholds interrupt acknowledge
// - Call on full stack drops oldest
// - ALU updates status and result
// - Arithmetic, logic, rotate, step, skip ops
// - 2K by 15-bit program memory
// - Execution starts at address zero
// - Table address from both pointer registers; last-page read uses page 7 and the low pointer only
// - Table read: low byte out, high latched
// - High-byte latch is read-only
// - Table reads take two cycles
// - Four phases per instruction cycle
// - Branches take two machine cycles
module pcst_sequencer
	import pcst_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [PC_W-1:0] pm_addr,
	input wire logic [WORD_W-1:0] pm_data,
	output pcst_phase_e cycle_phase,
	output logic dummy_cycle,
	output logic op_take,
	input wire logic op_valid,
	input wire pcst_op_e op_kind,
	input wire pcst_alu_e alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [PC_W-1:0] op_target,
	input wire logic irq_req,
	input wire logic [PC_W-1:0] irq_vector,
	output logic irq_ack,
	output logic [7:0] result,
	output logic result_valid
);
	pcst_phase_e phase_r;
	logic [PC_W-1:0] pc_r;
	logic dummy_r, op_take_r, irq_sel_r, pcl_sel_r;
	logic pcl_pend_r;
	logic [7:0] pcl_val_r, tpl_r;
	logic [2:0] tph_r;
	logic [PC_W-1:0] stk_r [STACK_DEPTH];
	logic [2:0] depth_r;
	logic tab_pend_r;
	logic [PC_W-1:0] tab_addr_r;
	logic [7:0] table_high_byte_latch_r, result_r;
	logic result_valid_r, irq_ack_r;
	logic [3:0] status_r;
	logic [PC_W-1:0] pm_addr_r;
	logic dp_wr_r;
	logic [7:0] dp_addr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic op_go, do_push, do_pop, skip_hit, irq_ok;
	logic [11:0] alu_out;
	logic [PC_W-1:0] push_val;

	// Add/sub/decimal/logic/rotate/step; returns {ov,z,ac,c,result}
	function automatic logic [11:0] alu_calc(input pcst_alu_e op,
		input logic [7:0] a, input logic [7:0] b, input logic ci,
		input logic ai);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] bb, r;
		logic cin, c, ac, ov;
		s = 9'h000;
		h = 5'h00;
		r = 8'h00;
		c = ci;
		ac = ai;
		ov = 1'b0;
		bb = (op == ALU_SUB || op == ALU_SBC) ? ~b : b;
		cin = (op == ALU_SUB) ? 1'b1
			: ((op == ALU_ADC || op == ALU_SBC) ? ci : 1'b0);
		case (op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
			begin
				s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
				h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
				r = s[7:0];
				c = s[8];
				ac = h[4];
				ov = (a[7] == bb[7]) && (r[7] != a[7]);
			end
			ALU_DAA:
			begin
				s = {1'b0, a};
				if (a[3:0] > 4'h9 || ai)
					s = s + {1'b0, DAA_LO};
				if (s[7:4] > 4'h9 || ci || s[8])
					s = s + DAA_HI;
				r = s[7:0];
				c = s[8] | ci;
			end
			ALU_AND: r = a & b;
			ALU_OR: r = a | b;
			ALU_XOR: r = a ^ b;
			ALU_CPL: r = ~a;
			ALU_RR: r = {a[0], a[7:1]};
			ALU_RRC:
			begin
				r = {ci, a[7:1]};
				c = a[0];
			end
			ALU_RL: r = {a[6:0], a[7]};
			ALU_RLC:
			begin
				r = {a[6:0], ci};
				c = a[7];
			end
			ALU_INC: r = a + 8'h01;
			ALU_DEC: r = a - 8'h01;
			default: r = a;
		endcase
		return {ov, (r == 8'h00), ac, c, r};
	endfunction : alu_calc

	// Execute-edge decode of the current slot
	always_comb
	begin
		alu_out = alu_calc(alu_op, alu_a, alu_b, status_r[ST_C],
			status_r[ST_AC]);
		op_go = (phase_r == PH_T4) && op_take_r && op_valid;
		skip_hit = op_go && ((op_kind == OP_SKIPZ && alu_out[10])
			|| (op_kind == OP_SKIPNZ && !alu_out[10]));
		do_push = (phase_r == PH_T4)
			&& (irq_sel_r || (op_go && op_kind == OP_CALL));
		do_pop = op_go && (op_kind == OP_RET || op_kind == OP_INTERRUPT_RETURN_OP);
		push_val = irq_sel_r ? pc_r - 11'h001 : pc_r;
		irq_ok = irq_req && (depth_r != DEPTH_FULL);
	end

	// Four-phase instruction cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			phase_r <= PH_T1;
		else
		begin
			unique case (phase_r)
				PH_T1: phase_r <= PH_T2;
				PH_T2: phase_r <= PH_T3;
				PH_T3: phase_r <= PH_T4;
				PH_T4: phase_r <= PH_T1;
			endcase
		end
	end

	// Slot selection made at T3, held through T4
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op_take_r <= 1'b0;
			irq_sel_r <= 1'b0;
			pcl_sel_r <= 1'b0;
		end
		else if (phase_r == PH_T3)
		begin
			pcl_sel_r <= !dummy_r && pcl_pend_r;
			irq_sel_r <= !dummy_r && !pcl_pend_r && irq_ok;
			op_take_r <= !dummy_r && !pcl_pend_r && !irq_ok;
		end
		else if (phase_r == PH_T4)
		begin
			op_take_r <= 1'b0;
			irq_sel_r <= 1'b0;
			pcl_sel_r <= 1'b0;
		end
	end

	// Program counter: step at T1, redirect at T4
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pc_r <= RESET_VECTOR;
		else if (phase_r == PH_T1)
			pc_r <= pc_r + 11'h001;
		else if (phase_r == PH_T4)
		begin
			if (pcl_sel_r)
				pc_r <= {pc_r[10:8], pcl_val_r};
			else if (irq_sel_r)
				pc_r <= irq_vector;
			else if (op_go && (op_kind == OP_JUMP || op_kind == OP_CALL))
				pc_r <= op_target;
			else if (do_pop)
				pc_r <= stk_r[0];
		end
	end

	// Dummy slot after any redirect, taken skip or table read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dummy_r <= 1'b0;
		else if (phase_r == PH_T4)
		begin
			if (dummy_r)
				dummy_r <= 1'b0;
			else
				dummy_r <= pcl_sel_r || irq_sel_r || skip_hit
					|| (op_go && op_kind != OP_NONE && op_kind != OP_ALU
					&& op_kind != OP_SKIPZ && op_kind != OP_SKIPNZ);
		end
	end

	// Hidden four-level return stack; full push drops oldest
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			depth_r <= 3'h0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stk_r[i] <= RESET_VECTOR;
		end
		else if (do_push)
		begin
			for (int i = STACK_DEPTH - 1; i > 0; i--)
				stk_r[i] <= stk_r[i-1];
			stk_r[0] <= push_val;
			if (depth_r != DEPTH_FULL)
				depth_r <= depth_r + 3'h1;
		end
		else if (do_pop)
		begin
			for (int i = 0; i < STACK_DEPTH - 1; i++)
				stk_r[i] <= stk_r[i+1];
			if (depth_r != 3'h0)
				depth_r <= depth_r - 3'h1;
		end
	end

	// Interrupt acknowledge pulse
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_ack_r <= 1'b0;
		else
			irq_ack_r <= (phase_r == PH_T4) && irq_sel_r;
	end

	// Memory port: fetch at T1, table word at T2 of dummy slot
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pm_addr_r <= RESET_VECTOR;
		else if (phase_r == PH_T1)
			pm_addr_r <= pc_r;
		else if (phase_r == PH_T2 && tab_pend_r)
			pm_addr_r <= tab_addr_r;
	end

	// Table read request and address
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tab_pend_r <= 1'b0;
			tab_addr_r <= RESET_VECTOR;
		end
		else if (op_go && op_kind == OP_TABRD)
		begin
			tab_pend_r <= 1'b1;
			tab_addr_r <= {tph_r, tpl_r};
		end
		else if (op_go && op_kind == OP_TABLE_READ_LAST_PAGE_OP)
		begin
			tab_pend_r <= 1'b1;
			tab_addr_r <= {LAST_PAGE, tpl_r};
		end
		else if (phase_r == PH_T3)
			tab_pend_r <= 1'b0;
	end

	// Result port: ALU result or table low byte; latch gets high bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			result_r <= 8'h00;
			result_valid_r <= 1'b0;
			table_high_byte_latch_r <= 8'h00;
		end
		else if (phase_r == PH_T3 && tab_pend_r)
		begin
			result_r <= pm_data[7:0];
			table_high_byte_latch_r <= {1'b0, pm_data[14:8]};
			result_valid_r <= 1'b1;
		end
		else if (op_go && op_kind == OP_ALU)
		begin
			result_r <= alu_out[7:0];
			result_valid_r <= 1'b1;
		end
		else
			result_valid_r <= 1'b0;
	end

	// Status flags from every ALU or skip operation
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status_r <= STATUS_RST;
		else if (op_go && (op_kind == OP_ALU || op_kind == OP_SKIPZ
			|| op_kind == OP_SKIPNZ))
			status_r <= alu_out[11:8];
	end

	// Bus address phase capture and registered read data
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr_r <= 1'b0;
			dp_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b0;
		end
		else
		begin
			hreadyout_r <= 1'b1;
			dp_wr_r <= hsel && hready && htrans[1] && hwrite;
			dp_addr_r <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				unique case (haddr[7:0])
					A_PCL: hrdata_r <= {24'h000000, pc_r[7:0]};
					A_TPL: hrdata_r <= {24'h000000, tpl_r};
					A_TPH: hrdata_r <= {29'h00000000, tph_r};
					A_TABLE_HIGH_BYTE_LATCH: hrdata_r <= {24'h000000, table_high_byte_latch_r};
					A_STATUS: hrdata_r <= {28'h0000000, status_r};
					default: hrdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Bus writes: pointers and deferred short jump
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tpl_r <= 8'h00;
			tph_r <= 3'h0;
			pcl_val_r <= 8'h00;
			pcl_pend_r <= 1'b0;
		end
		else
		begin
			if (dp_wr_r && dp_addr_r == A_PCL)
			begin
				pcl_val_r <= hwdata[7:0];
				pcl_pend_r <= 1'b1;
			end
			else if (pcl_sel_r && phase_r == PH_T4)
				pcl_pend_r <= 1'b0;
			if (dp_wr_r && dp_addr_r == A_TPL)
				tpl_r <= hwdata[7:0];
			if (dp_wr_r && dp_addr_r == A_TPH)
				tph_r <= hwdata[2:0];
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign pm_addr = pm_addr_r;
	assign cycle_phase = phase_r;
	assign dummy_cycle = dummy_r;
	assign op_take = op_take_r;
	assign irq_ack = irq_ack_r;
	assign result = result_r;
	assign result_valid = result_valid_r;

	// Checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_full_cycle;
		phase_r == PH_T2 ##1 phase_r == PH_T3 ##1 phase_r == PH_T4
			##1 phase_r == PH_T1;
	endsequence
	sequence s_tab_done;
		dummy_r ##2 pm_addr_r == tab_addr_r ##1 result_valid_r && !table_high_byte_latch_r[7];
	endsequence

	chk_phase_order: assert property (phase_r == PH_T1 |=> s_full_cycle)
		else $error("phase order broken");
	chk_pc_fetch_step: assert property (phase_r == PH_T1 |=>
		pm_addr_r == $past(pc_r) && pc_r == pm_addr_r + 11'h001)
		else $error("fetch step wrong");
	chk_pcl_jump: assert property (phase_r == PH_T4 && pcl_sel_r |=>
		pc_r == {$past(pc_r[10:8]), $past(pcl_val_r)} && dummy_r)
		else $error("short jump wrong");
	chk_call_push: assert property (op_go && op_kind == OP_CALL |=>
		pc_r == $past(op_target) && stk_r[0] == $past(pc_r))
		else $error("call push wrong");
	chk_ret_pop: assert property (do_pop && depth_r != 3'h0 |=>
		pc_r == $past(stk_r[0]) && depth_r == $past(depth_r) - 3'h1)
		else $error("return pop wrong");
	chk_full_no_ack: assert property (phase_r == PH_T3 && depth_r == DEPTH_FULL
		|=> !irq_sel_r ##1 !irq_ack_r)
		else $error("ack on full stack");
	chk_full_overflow: assert property (do_push && depth_r == DEPTH_FULL |=>
		depth_r == DEPTH_FULL && stk_r[3] == $past(stk_r[2]))
		else $error("overflow handling wrong");
	chk_reset_start: assert property ($rose(hresetn) |->
		pc_r == RESET_VECTOR && depth_r == 3'h0)
		else $error("reset state wrong");
	chk_branch_dummy: assert property (skip_hit || (op_go && op_kind == OP_JUMP)
		|=> dummy_r [*4] ##1 !dummy_r)
		else $error("dummy slot wrong");
	chk_table_timing: assert property (op_go && op_kind == OP_TABRD
		|=> s_tab_done)
		else $error("table read timing wrong");
	chk_table_last: assert property (op_go && op_kind == OP_TABLE_READ_LAST_PAGE_OP |=>
		tab_addr_r == {LAST_PAGE, $past(tpl_r)})
		else $error("last page address wrong");
	chk_alu_status: assert property (op_go && op_kind == OP_ALU |=>
		result_valid_r && status_r[ST_Z] == (result_r == 8'h00))
		else $error("status not updated");
endmodule : pcst_sequencer
`default_nettype wire

// ==== verif/pcst_far_model.sv ====
// Far-side model: program memory and interrupt pending flag
`timescale 1ns/1ps
`default_nettype none
module pcst_far_model
	import pcst_pkg::*;
#(
	parameter logic [PC_W-1:0] VEC = 11'h008
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [PC_W-1:0] pm_addr,
	output logic [WORD_W-1:0] pm_data,
	input wire logic irq_set,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [PC_W-1:0] irq_vector
);
	// Word of 15 bits per address, high part scrambled
	assign pm_data = {pm_addr[10:4] ^ 7'h55, pm_addr[7:0]};
	assign irq_vector = VEC;
	// Pending flag stays set until acknowledged
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_req <= 1'b0;
		else if (irq_set)
			irq_req <= 1'b1;
		else if (irq_ack)
			irq_req <= 1'b0;
	end
endmodule : pcst_far_model
`default_nettype wire

// ==== verif/test_program_counter_stack_table_read.sv ====
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module test_program_counter_stack_table_read
	import pcst_pkg::*;
;
	logic hclk, hresetn, hwrite, op_valid, irq_set;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic hreadyout, hresp, dummy_cycle, op_take, irq_req, irq_ack;
	logic result_valid;
	logic [PC_W-1:0] pm_addr, op_target, irq_vector;
	logic [WORD_W-1:0] pm_data;
	pcst_phase_e cycle_phase;
	pcst_op_e op_kind;
	pcst_alu_e alu_op;
	logic [7:0] alu_a, alu_b, result;
	int n_mismatch, tests_run, i, hits;
	localparam logic [7:0] EXP_ALU [16] = '{8'h10, 8'h11, 8'hd0, 8'hd0,
		8'h56, 8'h20, 8'hf0, 8'hd0, 8'h0f, 8'h78, 8'hf8, 8'he1, 8'he0,
		8'hf1, 8'hef, 8'hf0};
	// Device and far side
	pcst_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pm_addr(pm_addr),
		.pm_data(pm_data), .cycle_phase(cycle_phase),
		.dummy_cycle(dummy_cycle), .op_take(op_take), .op_valid(op_valid),
		.op_kind(op_kind), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
		.op_target(op_target), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_ack(irq_ack), .result(result), .result_valid(result_valid));
	pcst_far_model far_u (.hclk(hclk), .hresetn(hresetn), .pm_addr(pm_addr),
		.pm_data(pm_data), .irq_set(irq_set), .irq_ack(irq_ack),
		.irq_req(irq_req), .irq_vector(irq_vector));
	// Clock of 4 ns
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// Value compare
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Verdict and end of run
	task results;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// One single AHB-Lite word transfer
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		int k;
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		@(posedge hclk);
		for (k = 0; k < 16 && hreadyout !== 1'b1; k++) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		for (k = 0; k < 16 && hreadyout !== 1'b1; k++) @(posedge hclk);
		q = hrdata;
	endtask : bus
	// Offer an op until the slot takes it
	task issue(input pcst_op_e k, input pcst_alu_e f, input logic [7:0] a,
		input logic [7:0] b, input logic [10:0] t);
		int n;
		@(posedge hclk);
		op_kind <= k;
		alu_op <= f;
		alu_a <= a;
		alu_b <= b;
		op_target <= t;
		op_valid <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge hclk);
			if (op_take === 1'b1 && cycle_phase === PH_T4) break;
		end
		op_valid <= 1'b0;
		check(32'(n < 64), 32'h1);
	endtask : issue
	// Step to the next second phase
	task to_t2;
		int n;
		for (n = 0; n < 16; n++)
		begin
			@(posedge hclk);
			#1;
			if (cycle_phase === PH_T2) break;
		end
	endtask : to_t2
	// Branch, then check the dummy slot's fetch
	task br(input pcst_op_e k, input logic [10:0] t, input logic [10:0] e);
		issue(k, ALU_PASS, 8'h00, 8'h00, t);
		to_t2;
		check(dummy_cycle, 1'b1);
		check(pm_addr, e);
	endtask : br
	// Registers, unmapped space, bus response
	task t_regs;
		bus(1'b1, A_TPH, 32'hff, rd);
		bus(1'b0, A_TPH, 32'h0, rd);
		check(rd, 32'h7);
		bus(1'b0, 8'h20, 32'h0, rd);
		check(rd, 32'h0);
		check(hresp, 1'b0);
	endtask : t_regs
	// Table read: pointer, timing, byte split, latch
	task t_table(input pcst_op_e k, input logic [7:0] th, input logic [7:0] tl,
		input logic [7:0] lo, input logic [7:0] hi);
		int n;
		bus(1'b1, A_TPL, {24'h0, tl}, rd);
		bus(1'b1, A_TPH, {24'h0, th}, rd);
		issue(k, ALU_PASS, 8'h00, 8'h00, 11'h0);
		for (n = 1; n < 9; n++)
		begin
			@(posedge hclk);
			#1;
			if (result_valid === 1'b1) break;
		end
		check(32'(n), 32'h3);
		check(dummy_cycle, 1'b1);
		check(result, lo);
		bus(1'b1, A_TABLE_HIGH_BYTE_LATCH, 32'hff, rd);
		bus(1'b0, A_TABLE_HIGH_BYTE_LATCH, 32'h0, rd);
		check(rd, {24'h0, hi});
	endtask : t_table
	// Every ALU code with fixed operands
	task t_alu;
		int n;
		for (i = 0; i < 16; i++)
		begin
			issue(OP_ALU, pcst_alu_e'(i), 8'hf0, 8'h20, 11'h0);
			for (n = 0; n < 8 && result_valid !== 1'b1; n++) @(posedge hclk);
			check(result, EXP_ALU[i]);
			if (i == 0)
			begin
				bus(1'b0, A_STATUS, 32'h0, rd);
				check({rd[ST_Z], rd[ST_C]}, 2'b01);
			end
		end
	endtask : t_alu
	// Jump, calls past a full stack, held interrupt, returns
	task t_stack;
		br(OP_JUMP, 11'h100, 11'h100);
		to_t2;
		check(pm_addr, 11'h101);
		check(dummy_cycle, 1'b0);
		for (i = 2; i < 7; i++)
			br(OP_CALL, 11'(i * 256), 11'(i * 256));
		@(posedge hclk);
		irq_set <= 1'b1;
		@(posedge hclk);
		irq_set <= 1'b0;
		hits = 0;
		repeat (48)
		begin
			@(posedge hclk);
			#1;
			if (irq_ack === 1'b1) hits++;
		end
		check(32'(hits), 32'h0);
		br(OP_RET, 11'h0, 11'h502);
		for (i = 0; i < 32 && irq_ack !== 1'b1; i++) @(posedge hclk);
		check(irq_ack, 1'b1);
		#1;
		check(pm_addr, 11'h008);
		br(OP_INTERRUPT_RETURN_OP, 11'h0, 11'h503);
		for (i = 4; i > 1; i--)
			br(OP_RET, 11'h0, 11'(i * 256 + 2));
	endtask : t_stack
	// Low byte write: short jump, dummy slot, read back
	task t_pcl;
		br(OP_JUMP, 11'h345, 11'h345);
		bus(1'b1, A_PCL, 32'h22, rd);
		to_t2;
		to_t2;
		check(dummy_cycle, 1'b1);
		check(pm_addr, 11'h322);
		bus(1'b0, A_PCL, 32'h0, rd);
		check(rd, 32'h23);
	endtask : t_pcl
	// Skips taken and not taken, plain slot
	task t_skip;
		issue(OP_SKIPZ, ALU_SUB, 8'h33, 8'h33, 11'h0);
		to_t2;
		check(dummy_cycle, 1'b1);
		bus(1'b0, A_STATUS, 32'h0, rd);
		check(rd[ST_Z], 1'b1);
		issue(OP_SKIPNZ, ALU_SUB, 8'h33, 8'h33, 11'h0);
		to_t2;
		check(dummy_cycle, 1'b0);
		issue(OP_NONE, ALU_PASS, 8'h00, 8'h00, 11'h0);
		to_t2;
		check(dummy_cycle, 1'b0);
	endtask : t_skip
	// Reset in mid-run empties the stack and restarts at zero
	task t_reset;
		br(OP_CALL, 11'h155, 11'h155);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		check(hreadyout, 1'b1);
		check(pm_addr, RESET_VECTOR);
		check(cycle_phase, PH_T2);
		br(OP_RET, 11'h0, RESET_VECTOR);
	endtask : t_reset
	// Main sequence
	initial
	begin
		{hresetn, hwrite, op_valid, irq_set, htrans} = '0;
		{haddr, hwdata, op_target, alu_a, alu_b} = '0;
		op_kind = OP_NONE;
		alu_op = ALU_ADD;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		check(hreadyout, 1'b1);
		check(pm_addr, RESET_VECTOR);
		check(cycle_phase, PH_T2);
		t_regs;
		t_table(OP_TABRD, 8'h07, 8'h06, 8'h06, 8'h25);
		t_table(OP_TABLE_READ_LAST_PAGE_OP, 8'h00, 8'h1b, 8'h1b, 8'h24);
		t_alu;
		t_stack;
		t_pcl;
		t_skip;
		t_reset;
		results;
	end
	// Hang guard
	initial
	begin
		#100000;
		n_mismatch++;
		results;
	end
endmodule : test_program_counter_stack_table_read
`default_nettype wire
